// *** verilog/fts_frame_sync.sv ***
// Our own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
module fts_frame_sync (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // axi4-lite write address
  input wire logic [fts_pkg::FTS_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [fts_pkg::FTS_DW-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [fts_pkg::FTS_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [fts_pkg::FTS_DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // sync pins, bit 0 horizontal, 1 vertical, 2 composite, active low
  input wire logic [fts_pkg::FTS_NPIN-1:0] sync_pin_in,
  output logic [fts_pkg::FTS_NPIN-1:0] sync_pin_out,
  output logic [fts_pkg::FTS_NPIN-1:0] sync_pin_oe
);
  import fts_pkg::*;

  typedef struct packed {
    logic [1:0] hsync_pin_mode;
    logic [1:0] vsync_pin_mode;
    logic [1:0] composite_sync_pin_pin_mode;
    logic sync_follow_select;
    logic [FTS_CW-1:0] line_length_limit;
    logic [FTS_CW-1:0] field_length_limit;
    logic [FTS_CW-1:0] horiz_preload;
    logic [FTS_CW-1:0] vert_preload;
    logic [FTS_CW-1:0] serration_sample_point;
    logic [FTS_CW-1:0] hsync_width;
    logic [FTS_CW-1:0] vsync_width;
    logic [FTS_CW-1:0] horiz_counter;
    logic [FTS_CW-1:0] vert_counter;
    logic serr_seen;
    logic [2:0] pin_out;
    logic [2:0] pin_oe;
    fts_wst_t wst;
    fts_rst_t rst;
    logic aw_have;
    logic w_have;
    logic [FTS_AW-1:0] awaddr;
    logic [FTS_DW-1:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [FTS_DW-1:0] rdata;
    logic [1:0] rresp;
  } fts_st_t;

  fts_st_t st_reg;
  fts_st_t st_next;

  fts_sync_if sif ();
  logic h_load;
  logic v_load;
  logic line_end;
  logic field_end;
  logic samp_hit;
  logic serr_first;
  logic start_h;
  logic start_v;
  logic h_act;
  logic v_act;
  logic [2:0] pin_act;

  // ----------------------------------------------------------------
  // register readback, bit 32 flags a mapped address
  // ----------------------------------------------------------------
  function automatic logic [FTS_DW:0] reg_word(input fts_st_t s, input logic [FTS_AW-1:0] a);
    logic [FTS_DW-1:0] w;
    logic hit;
    w = '0;
    hit = 1'b1;
    case (a)
      FTS_CTRL_OFS: begin
        w[FTS_HMODE_LSB +: 2] = s.hsync_pin_mode;
        w[FTS_VMODE_LSB +: 2] = s.vsync_pin_mode;
        w[FTS_CMODE_LSB +: 2] = s.composite_sync_pin_pin_mode;
        w[FTS_FOLLOW_BIT] = s.sync_follow_select;
      end
      FTS_LINE_LIM_OFS: w[FTS_LO_LSB +: FTS_CW] = s.line_length_limit;
      FTS_FIELD_LIM_OFS: w[FTS_LO_LSB +: FTS_CW] = s.field_length_limit;
      FTS_HPRE_OFS: w[FTS_LO_LSB +: FTS_CW] = s.horiz_preload;
      FTS_VPRE_OFS: w[FTS_LO_LSB +: FTS_CW] = s.vert_preload;
      FTS_SAMP_OFS: w[FTS_LO_LSB +: FTS_CW] = s.serration_sample_point;
      FTS_WIDTH_OFS: begin
        w[FTS_LO_LSB +: FTS_CW] = s.hsync_width;
        w[FTS_HI_LSB +: FTS_CW] = s.vsync_width;
      end
      FTS_COUNT_OFS: begin
        w[FTS_LO_LSB +: FTS_CW] = s.horiz_counter;
        w[FTS_HI_LSB +: FTS_CW] = s.vert_counter;
      end
      default: hit = 1'b0;
    endcase
    return {hit, w};
  endfunction

  // ----------------------------------------------------------------
  // input edges and counter events
  // ----------------------------------------------------------------
  assign sif.pin_level = sync_pin_in;
  assign sif.pin_input_en[FTS_PIN_H] = (st_reg.hsync_pin_mode == FTS_MODE_IN);
  assign sif.pin_input_en[FTS_PIN_V] = (st_reg.vsync_pin_mode == FTS_MODE_IN);
  assign sif.pin_input_en[FTS_PIN_C] = (st_reg.composite_sync_pin_pin_mode == FTS_MODE_IN);

  fts_edge_detect u_edge (
    .mclk(mclk),
    .reset(reset),
    .sif(sif)
  );

  assign line_end = (st_reg.horiz_counter == st_reg.line_length_limit);
  assign field_end = line_end && (st_reg.vert_counter == st_reg.field_length_limit);
  assign samp_hit = (st_reg.horiz_counter == st_reg.serration_sample_point);
  // a low sample after a high one marks the start of vertical sync
  assign serr_first = samp_hit && sif.pin_input_en[FTS_PIN_C]
    && !sif.sync_level[FTS_PIN_C] && !st_reg.serr_seen;
  assign h_load = sif.fall[FTS_PIN_H] | sif.fall[FTS_PIN_C];
  assign v_load = sif.fall[FTS_PIN_V] | serr_first;
  // counter pulses always; external ones only when following
  assign start_h = line_end | (st_reg.sync_follow_select & h_load);
  assign start_v = field_end | (st_reg.sync_follow_select & v_load);

  fts_pulse u_hpulse (
    .mclk(mclk),
    .reset(reset),
    .start(start_h),
    .tick(1'b1),
    .width(st_reg.hsync_width),
    .active(h_act)
  );

  // vertical pulse width counts lines, not clocks
  fts_pulse u_vpulse (
    .mclk(mclk),
    .reset(reset),
    .start(start_v),
    .tick(line_end),
    .width(st_reg.vsync_width),
    .active(v_act)
  );

  assign pin_act[FTS_PIN_H] = h_act;
  assign pin_act[FTS_PIN_V] = v_act;
  assign pin_act[FTS_PIN_C] = h_act ^ v_act;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [FTS_DW:0] rw;
    logic [FTS_DW-1:0] mask;
    logic [FTS_DW-1:0] mg;
    rw = '0;
    mask = '0;
    mg = '0;
    st_next = st_reg;

    // counters ignore the follow select entirely
    if (h_load) begin
      st_next.horiz_counter = st_reg.horiz_preload;
    end else if (line_end) begin
      st_next.horiz_counter = '0;
    end else begin
      st_next.horiz_counter = st_reg.horiz_counter + 16'h0001;
    end
    if (v_load) begin
      st_next.vert_counter = st_reg.vert_preload;
    end else if (field_end) begin
      st_next.vert_counter = '0;
    end else if (line_end) begin
      st_next.vert_counter = st_reg.vert_counter + 16'h0001;
    end
    if (samp_hit && sif.pin_input_en[FTS_PIN_C]) begin
      st_next.serr_seen = ~sif.sync_level[FTS_PIN_C];
    end

    // pins registered once more so the edge-to-pin path is four clocks
    st_next.pin_out = ~pin_act;
    st_next.pin_oe[FTS_PIN_H] = (st_reg.hsync_pin_mode == FTS_MODE_OUT);
    st_next.pin_oe[FTS_PIN_V] = (st_reg.vsync_pin_mode == FTS_MODE_OUT);
    st_next.pin_oe[FTS_PIN_C] = (st_reg.composite_sync_pin_pin_mode == FTS_MODE_OUT);

    // write channel: address and data accepted in either order
    case (st_reg.wst)
      FTS_W_IDLE: begin
        if (s_axi_awvalid && st_reg.awready) begin
          st_next.aw_have = 1'b1;
          st_next.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_reg.wready) begin
          st_next.w_have = 1'b1;
          st_next.wdata = s_axi_wdata;
          st_next.wstrb = s_axi_wstrb;
        end
        if (st_next.aw_have && st_next.w_have) begin
          rw = reg_word(st_reg, st_next.awaddr);
          mask = {{8{st_next.wstrb[3]}}, {8{st_next.wstrb[2]}},
                  {8{st_next.wstrb[1]}}, {8{st_next.wstrb[0]}}};
          mg = (rw[FTS_DW-1:0] & ~mask) | (st_next.wdata & mask);
          st_next.bresp = rw[FTS_DW] ? FTS_RESP_OKAY : FTS_RESP_SLVERR;
          case (st_next.awaddr)
            FTS_CTRL_OFS: begin
              st_next.hsync_pin_mode = mg[FTS_HMODE_LSB +: 2];
              st_next.vsync_pin_mode = mg[FTS_VMODE_LSB +: 2];
              st_next.composite_sync_pin_pin_mode = mg[FTS_CMODE_LSB +: 2];
              st_next.sync_follow_select = mg[FTS_FOLLOW_BIT];
            end
            FTS_LINE_LIM_OFS: st_next.line_length_limit = mg[FTS_LO_LSB +: FTS_CW];
            FTS_FIELD_LIM_OFS: st_next.field_length_limit = mg[FTS_LO_LSB +: FTS_CW];
            FTS_HPRE_OFS: st_next.horiz_preload = mg[FTS_LO_LSB +: FTS_CW];
            FTS_VPRE_OFS: st_next.vert_preload = mg[FTS_LO_LSB +: FTS_CW];
            FTS_SAMP_OFS: st_next.serration_sample_point = mg[FTS_LO_LSB +: FTS_CW];
            FTS_WIDTH_OFS: begin
              st_next.hsync_width = mg[FTS_LO_LSB +: FTS_CW];
              st_next.vsync_width = mg[FTS_HI_LSB +: FTS_CW];
            end
            default: begin
            end
          endcase
          st_next.bvalid = 1'b1;
          st_next.wst = FTS_W_RESP;
        end
        st_next.awready = !st_next.aw_have;
        st_next.wready = !st_next.w_have;
      end
      FTS_W_RESP: begin
        if (s_axi_bready) begin
          st_next.bvalid = 1'b0;
          st_next.aw_have = 1'b0;
          st_next.w_have = 1'b0;
          st_next.awready = 1'b1;
          st_next.wready = 1'b1;
          st_next.wst = FTS_W_IDLE;
        end
      end
      default: st_next.wst = FTS_W_IDLE;
    endcase

    // read channel: one cycle to answer, counters read live
    case (st_reg.rst)
      FTS_R_IDLE: begin
        if (s_axi_arvalid) begin
          rw = reg_word(st_reg, s_axi_araddr);
          st_next.rdata = rw[FTS_DW-1:0];
          st_next.rresp = rw[FTS_DW] ? FTS_RESP_OKAY : FTS_RESP_SLVERR;
          st_next.rvalid = 1'b1;
          st_next.arready = 1'b0;
          st_next.rst = FTS_R_DATA;
        end
      end
      FTS_R_DATA: begin
        if (s_axi_rready) begin
          st_next.rvalid = 1'b0;
          st_next.arready = 1'b1;
          st_next.rst = FTS_R_IDLE;
        end
      end
      default: st_next.rst = FTS_R_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      st_reg <= '0;
      st_reg.hsync_pin_mode <= FTS_MODE_HIZ;
      st_reg.vsync_pin_mode <= FTS_MODE_HIZ;
      st_reg.composite_sync_pin_pin_mode <= FTS_MODE_HIZ;
      st_reg.line_length_limit <= FTS_RST_LIM;
      st_reg.field_length_limit <= FTS_RST_LIM;
      st_reg.horiz_preload <= FTS_RST_PRE;
      st_reg.vert_preload <= FTS_RST_PRE;
      st_reg.serration_sample_point <= FTS_RST_SAMP;
      st_reg.hsync_width <= FTS_RST_HWID;
      st_reg.vsync_width <= FTS_RST_VWID;
      st_reg.pin_out <= FTS_RST_LEVEL;
      st_reg.wst <= FTS_W_IDLE;
      st_reg.rst <= FTS_R_IDLE;
      st_reg.awready <= 1'b1;
      st_reg.wready <= 1'b1;
      st_reg.arready <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign s_axi_awready = st_reg.awready;
  assign s_axi_wready = st_reg.wready;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = st_reg.arready;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;
  assign sync_pin_out = st_reg.pin_out;
  assign sync_pin_oe = st_reg.pin_oe;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking

  property p_hiz_reset;
    reset |=> sync_pin_oe == 3'h0;
  endproperty
  a_hiz_reset: assert property (p_hiz_reset) else $error("pin driven after reset");

  property p_hclear;
    disable iff (reset) line_end && !h_load |=> st_reg.horiz_counter == 16'h0000;
  endproperty
  a_hclear: assert property (p_hclear) else $error("horizontal counter missed clear");

  property p_vclear;
    disable iff (reset) field_end && !v_load |=> st_reg.vert_counter == 16'h0000;
  endproperty
  a_vclear: assert property (p_vclear) else $error("vertical counter missed clear");

  property p_hsync_out;
    disable iff (reset) line_end |-> ##2 !sync_pin_out[FTS_PIN_H];
  endproperty
  a_hsync_out: assert property (p_hsync_out) else $error("no sync pulse after clear");

  property p_hload_lat;
    disable iff (reset)
      $fell(sync_pin_in[FTS_PIN_H]) && sif.pin_input_en[FTS_PIN_H]
      ##1 sif.pin_input_en[FTS_PIN_H] ##1 sif.pin_input_en[FTS_PIN_H]
      |=> st_reg.horiz_counter == $past(st_reg.horiz_preload);
  endproperty
  a_hload_lat: assert property (p_hload_lat) else $error("horizontal load late");

  property p_serr_load;
    disable iff (reset) serr_first |=> st_reg.vert_counter == $past(st_reg.vert_preload);
  endproperty
  a_serr_load: assert property (p_serr_load) else $error("serration did not load");

  property p_follow_off;
    disable iff (reset)
      !st_reg.sync_follow_select && h_load && !line_end && !h_act |=> !h_act;
  endproperty
  a_follow_off: assert property (p_follow_off) else $error("input edge drove output");

  property p_follow_on;
    disable iff (reset) st_reg.sync_follow_select && v_load |-> ##2 !sync_pin_out[FTS_PIN_V];
  endproperty
  a_follow_on: assert property (p_follow_on) else $error("follow mode missed pulse");

  property p_hiz_quiet;
    disable iff (reset) !sif.pin_input_en[FTS_PIN_C] |-> !sif.fall[FTS_PIN_C] && !serr_first;
  endproperty
  a_hiz_quiet: assert property (p_hiz_quiet) else $error("edge seen on non-input");

  c_hload: cover property (disable iff (reset) h_load);
  c_serr: cover property (disable iff (reset) serr_first);
  c_follow: cover property (disable iff (reset) st_reg.sync_follow_select && start_h);
  c_write: cover property (disable iff (reset) s_axi_bvalid && s_axi_bready);
endmodule

// *** inc/fts_pkg.sv ***
package fts_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int FTS_AW = 8;
  localparam int FTS_DW = 32;
  localparam int FTS_CW = 16;
  localparam int FTS_NPIN = 3;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] FTS_CTRL_OFS = 8'h00;
  localparam logic [7:0] FTS_LINE_LIM_OFS = 8'h04;
  localparam logic [7:0] FTS_FIELD_LIM_OFS = 8'h08;
  localparam logic [7:0] FTS_HPRE_OFS = 8'h0c;
  localparam logic [7:0] FTS_VPRE_OFS = 8'h10;
  localparam logic [7:0] FTS_SAMP_OFS = 8'h14;
  localparam logic [7:0] FTS_WIDTH_OFS = 8'h18;
  localparam logic [7:0] FTS_COUNT_OFS = 8'h1c;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int FTS_HMODE_LSB = 0;
  localparam int FTS_VMODE_LSB = 2;
  localparam int FTS_CMODE_LSB = 4;
  localparam int FTS_FOLLOW_BIT = 8;
  localparam int FTS_LO_LSB = 0;
  localparam int FTS_HI_LSB = 16;

  // pin index within the three sync pins
  localparam int FTS_PIN_H = 0;
  localparam int FTS_PIN_V = 1;
  localparam int FTS_PIN_C = 2;

  // ----------------------------------------------------------------
  // pin modes and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] FTS_MODE_HIZ = 2'h0;
  localparam logic [1:0] FTS_MODE_IN = 2'h1;
  localparam logic [1:0] FTS_MODE_OUT = 2'h2;
  localparam logic [15:0] FTS_RST_LIM = 16'hffff;
  localparam logic [15:0] FTS_RST_PRE = 16'h0000;
  localparam logic [15:0] FTS_RST_SAMP = 16'h0000;
  localparam logic [15:0] FTS_RST_HWID = 16'h0010;
  localparam logic [15:0] FTS_RST_VWID = 16'h0003;
  localparam logic [2:0] FTS_RST_LEVEL = 3'h7;

  // ----------------------------------------------------------------
  // bus answers and handshake states
  // ----------------------------------------------------------------
  localparam logic [1:0] FTS_RESP_OKAY = 2'h0;
  localparam logic [1:0] FTS_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {FTS_W_IDLE = 2'b01, FTS_W_RESP = 2'b10} fts_wst_t;
  typedef enum logic [1:0] {FTS_R_IDLE = 2'b01, FTS_R_DATA = 2'b10} fts_rst_t;

endpackage

// *** inc/fts_sync_if.sv ***
`timescale 1ns/1ps
interface fts_sync_if;
  logic [2:0] pin_level;
  logic [2:0] pin_input_en;
  logic [2:0] sync_level;
  logic [2:0] fall;

  modport det (input pin_level, input pin_input_en, output sync_level, output fall);
  modport core (output pin_level, output pin_input_en, input sync_level, input fall);
endinterface

// *** verilog/fts_edge_detect.sv ***
`timescale 1ns/1ps
module fts_edge_detect (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // pins in, strobes out
  fts_sync_if.det sif
);
  import fts_pkg::*;

  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] prev;
  } fts_edge_st_t;

  fts_edge_st_t edge_reg;
  fts_edge_st_t edge_next;

  // ----------------------------------------------------------------
  // two-flop synchroniser and previous sample
  // ----------------------------------------------------------------
  always_comb begin
    edge_next = edge_reg;
    edge_next.s1 = sif.pin_level;
    edge_next.s2 = edge_reg.s1;
    edge_next.prev = edge_reg.s2;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      edge_next_rst: edge_reg <= '{s1: FTS_RST_LEVEL, s2: FTS_RST_LEVEL, prev: FTS_RST_LEVEL};
    end else begin
      edge_reg <= edge_next;
    end
  end

  assign sif.sync_level = edge_reg.s2;

  // ----------------------------------------------------------------
  // falling edge strobes, only for pins set as inputs
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < FTS_NPIN; gi++) begin : g_fall
      assign sif.fall[gi] = sif.pin_input_en[gi] & edge_reg.prev[gi] & ~edge_reg.s2[gi];

      property p_fall_once;
        @(posedge mclk) disable iff (reset) sif.fall[gi] |=> !sif.fall[gi];
      endproperty
      a_fall_once: assert property (p_fall_once) else $error("fall strobe longer than one cycle");
    end
  endgenerate
endmodule

// *** verilog/fts_pulse.sv ***
`timescale 1ns/1ps
module fts_pulse (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // pulse control
  input wire logic start,
  input wire logic tick,
  input wire logic [fts_pkg::FTS_CW-1:0] width,
  // pulse out
  output logic active
);
  import fts_pkg::*;

  typedef struct packed {
    logic active;
    logic [FTS_CW-1:0] cnt;
  } fts_pulse_st_t;

  fts_pulse_st_t pulse_reg;
  fts_pulse_st_t pulse_next;

  // a zero width still gives one tick, so a start is never lost
  always_comb begin
    pulse_next = pulse_reg;
    if (start) begin
      pulse_next.active = 1'b1;
      pulse_next.cnt = width;
    end else if (pulse_reg.active && tick) begin
      if (pulse_reg.cnt <= 16'h0001) begin
        pulse_next.active = 1'b0;
      end
      pulse_next.cnt = pulse_reg.cnt - 16'h0001;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      pulse_reg <= '0;
    end else begin
      pulse_reg <= pulse_next;
    end
  end

  assign active = pulse_reg.active;
endmodule

// *** bench/fts_video_src.sv ***
`timescale 1ns/1ps
module fts_video_src (
  // clock
  input wire logic mclk,
  // pins to pull low, for as many clocks as each is held
  input wire logic [2:0] fire,
  // source levels, idle high
  output logic [2:0] level
);
  // ----
  // source
  // ----
  initial level = 3'h7;
  // each pulse lasts as many clocks as fire is held, one clock behind it
  always @(posedge mclk) begin
    level <= ~fire;
  end
endmodule

// *** bench/fts_frame_sync_tb.sv ***
`timescale 1ns/1ps
module fts_frame_sync_tb;
  import fts_pkg::*;
  localparam int LAT = 4;
  logic mclk = 1'b0, reset = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [1:0] bresp, rresp, r;
  logic [2:0] pout, poe, src, fire = 3'h0;
  wire logic [2:0] pin = (poe & pout) | (~poe & src);
  int n_fail = 0, tests_run = 0, cyc = 0, n;
  fts_frame_sync i_dut (.mclk(mclk), .reset(reset), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .sync_pin_in(pin), .sync_pin_out(pout), .sync_pin_oe(poe));
  fts_video_src i_src (.mclk(mclk), .fire(fire), .level(src));
  // ----
  // helpers
  // ----
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic pulse(input logic [2:0] p);
    @(posedge mclk);
    fire <= p;
    @(posedge mclk);
    fire <= 3'h0;
  endtask
  // counts falling clock samples until pin i goes high and then low again
  task automatic wait_fall(input int i);
    n = 0;
    while (pout[i] !== 1'b1) begin
      @(negedge mclk);
      n++;
    end
    while (pout[i] !== 1'b0) begin
      @(negedge mclk);
      n++;
    end
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_reset();
    check("oe", poe, 3'h0);
    check("pin out", pout, 3'h7);
    rd(FTS_CTRL_OFS);
    check("ctrl", d, 32'h0);
    rd(FTS_LINE_LIM_OFS);
    check("line limit", d, {16'h0, FTS_RST_LIM});
    rd(8'h20);
    check("unmapped resp", r, FTS_RESP_SLVERR);
  endtask
  // restart the counters so a short line limit is met before the counter passes it
  task automatic reset_dut();
    @(posedge mclk);
    reset <= 1'b1;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
  endtask
  task automatic t_free();
    reset_dut();
    wr(FTS_LINE_LIM_OFS, 32'h9);
    @(negedge mclk);
    check("oe after reset", poe, 3'h0);
    wr(FTS_WIDTH_OFS, 32'h00010003);
    wr(FTS_CTRL_OFS, {30'h0, FTS_MODE_OUT});
    @(negedge mclk);
    check("oe h only", poe, 3'h1);
    wait_fall(0);
    wait_fall(0);
    check("line period", n, 32'd10);
  endtask
  task automatic t_follow();
    wr(FTS_LINE_LIM_OFS, 32'hffff);
    wr(FTS_HPRE_OFS, 32'h4);
    wr(FTS_VPRE_OFS, 32'h5);
    wr(FTS_CTRL_OFS, 32'h125);
    pulse(3'h1);
    wait_fall(2);
    check("h to c latency", n, LAT + 1);
    pulse(3'h2);
    repeat (4) @(posedge mclk);
    rd(FTS_COUNT_OFS);
    check("vert load", d[31:16], 16'h5);
    repeat (200) @(posedge mclk);
    wr(FTS_CTRL_OFS, 32'h025);
    pulse(3'h1);
    n = 0;
    repeat (10) @(negedge mclk) n += (pout[0] === 1'b0);
    check("no follow output", n, 32'd0);
    rd(FTS_COUNT_OFS);
    check("load without follow", d[15:0] < 16'd60, 1'b1);
    repeat (200) @(posedge mclk);
    wr(FTS_CTRL_OFS, 32'h020);
    pulse(3'h1);
    repeat (4) @(posedge mclk);
    rd(FTS_COUNT_OFS);
    check("hiz ignores edge", d[15:0] > 16'd150, 1'b1);
  endtask
  // composite input only: short line pulse, then a long serration pulse
  task automatic t_serr();
    reset_dut();
    wr(FTS_SAMP_OFS, 32'h8);
    wr(FTS_HPRE_OFS, 32'h4);
    wr(FTS_VPRE_OFS, 32'h9);
    wr(FTS_CTRL_OFS, 32'h110);
    pulse(3'h4);
    wait_fall(0);
    check("c to h latency", n, LAT + 1);
    repeat (6) @(posedge mclk);
    rd(FTS_COUNT_OFS);
    check("high sample no serration", d[31:16], 16'h0);
    check("no vsync yet", pout[1], 1'b1);
    @(posedge mclk);
    fire <= 3'h4;
    repeat (12) @(posedge mclk);
    fire <= 3'h0;
    rd(FTS_COUNT_OFS);
    @(negedge mclk);
    check("serration loads vert", d[31:16], 16'h9);
    check("vsync on serration", pout[1], 1'b0);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    forever #25 mclk = ~mclk;
  end
  // hang guard, far above the several hundred cycles the run needs
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      summarize();
    end
  end
  initial begin
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    @(negedge mclk);
    t_reset();
    t_free();
    t_follow();
    t_serr();
    summarize();
  end
endmodule
